// ==== hdl/ahi_defs.svh ====
`ifndef AHI_DEFS_SVH
`define AHI_DEFS_SVH

`define AHI_PRE_RESET    2'h0
`define AHI_DIG_LAST     2'h3
`define AHI_RATIO_RESET  3'h3
`define AHI_RATIO_BASE   13'h0020
`define AHI_CMD_LAST     5'h07
`define AHI_CMD_READ_POS 0
`define AHI_WORD_16_LAST 5'h0f
`define AHI_WORD_24_LAST 5'h17
`define AHI_WORD_32_LAST 5'h1f
`define AHI_WORD_16      2'h0
`define AHI_WORD_24      2'h1

`endif

// ==== hdl/ahi_pkg.sv ====
`default_nettype none
package ahi_pkg;

  typedef enum logic {
    IF_SPI      = 1'b0,
    IF_TWO_WIRE = 1'b1
  } ahi_if_e;

  typedef enum logic [1:0] {
    SP_IDLE  = 2'b00,
    SP_CMD   = 2'b01,
    SP_WRITE = 2'b10,
    SP_READ  = 2'b11
  } ahi_spi_e;

  typedef struct packed {
    logic gainStrapHi;
    logic gainStrapLo;
    logic boostStrap;
    logic ratioStrapHi;
    logic ratioStrapLo;
  } ahi_strap_s;

  typedef struct packed {
    logic        cmdValid;
    logic [7:0]  cmd;
    logic        wrValid;
    logic [31:0] wrWord;
    logic        rdLoad;
  } ahi_spi_evt_s;

endpackage
`default_nettype wire

// ==== hdl/ahi_spi_port.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ahi_defs.svh"

module ahi_spi_port (
  input  wire logic                 core_clk,  // Master clock
  input  wire logic                 sys_rst,   // Async reset
  input  wire logic                 clkEn,     // Freezes state when low
  input  wire logic                 enable,    // Port usable
  input  wire logic                 sck,       // Serial clock pin
  input  wire logic                 csN,       // Chip select pin
  input  wire logic                 sdi,       // Serial data in
  input  wire logic [1:0]           wordLen,   // 0:16 1:24 else 32
  input  wire logic [31:0]          rdData,    // Read word, MSB first
  output logic                      sdo,       // Serial data out
  output logic                      sdoOe,     // Drive enable
  output logic                      sckRise,   // Synced rising edge
  output logic                      sckFall,   // Synced falling edge
  output ahi_pkg::ahi_spi_evt_s     evt        // Command and data events
);

  // ---------------------------------------------
  // Synchronizers
  // ---------------------------------------------
  logic sckS1, sckS2, sckS3, csS1, csS2, csS3, sdiS1, sdiS2;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {sckS1, sckS2, sckS3} <= 3'h0;
      {csS1, csS2, csS3}    <= 3'h7;
      {sdiS1, sdiS2}        <= 2'h0;
    end else if (clkEn) begin
      {sckS1, sckS2, sckS3} <= {sck, sckS1, sckS2};
      {csS1, csS2, csS3}    <= {csN, csS1, csS2};
      {sdiS1, sdiS2}        <= {sdi, sdiS1};
    end
  end

  // Both clock modes share one edge pair, so idle level needs no setting
  assign sckRise = clkEn & sckS2 & ~sckS3;
  assign sckFall = clkEn & ~sckS2 & sckS3;

  function automatic logic [4:0] wordLast(input logic [1:0] len);
    unique case (len)
      `AHI_WORD_16: wordLast = `AHI_WORD_16_LAST;
      `AHI_WORD_24: wordLast = `AHI_WORD_24_LAST;
      default:      wordLast = `AHI_WORD_32_LAST;
    endcase
  endfunction

  // ---------------------------------------------
  // Transfer sequencer
  // ---------------------------------------------
  ahi_pkg::ahi_spi_e     stReg, stNext;
  logic [4:0]            cntReg, cntNext;
  logic [31:0]           inReg, inNext, outReg, outNext;
  logic                  sdoReg, sdoNext;
  ahi_pkg::ahi_spi_evt_s evtReg, evtNext;

  always_comb begin
    logic [7:0] cmdByte;
    cmdByte = {inReg[6:0], sdiS2};
    stNext = stReg;
    cntNext = cntReg;
    inNext = inReg;
    outNext = outReg;
    sdoNext = sdoReg;
    evtNext = evtReg;
    evtNext.cmdValid = 1'b0;
    evtNext.wrValid = 1'b0;
    evtNext.rdLoad = 1'b0;
    if (!enable || csS2) begin
      stNext = ahi_pkg::SP_IDLE;
    end else if (csS3 && !csS2) begin
      stNext = ahi_pkg::SP_CMD;
      cntNext = 5'h00;
      inNext = 32'h0000_0000;
    end else begin
      unique case (stReg)
        ahi_pkg::SP_IDLE: ;
        ahi_pkg::SP_CMD: if (sckRise) begin
          inNext = 32'h0000_0000;
          cntNext = cntReg + 5'h01;
          if (cntReg == `AHI_CMD_LAST) begin
            evtNext.cmdValid = 1'b1;
            evtNext.cmd = cmdByte;
            cntNext = 5'h00;
            if (cmdByte[`AHI_CMD_READ_POS]) begin
              stNext = ahi_pkg::SP_READ;
              outNext = rdData;
              evtNext.rdLoad = 1'b1;
            end else begin
              stNext = ahi_pkg::SP_WRITE;
            end
          end else begin
            inNext = {inReg[30:0], sdiS2};
          end
        end
        ahi_pkg::SP_WRITE: if (sckRise) begin
          inNext = {inReg[30:0], sdiS2};
          cntNext = cntReg + 5'h01;
          if (cntReg == wordLast(wordLen)) begin
            evtNext.wrValid = 1'b1;
            evtNext.wrWord = {inReg[30:0], sdiS2};
            inNext = 32'h0000_0000;
            cntNext = 5'h00;
          end
        end
        ahi_pkg::SP_READ: if (sckFall) begin
          sdoNext = outReg[31];
          outNext = {outReg[30:0], 1'b0};
          cntNext = cntReg + 5'h01;
          if (cntReg == wordLast(wordLen)) begin
            outNext = rdData;
            evtNext.rdLoad = 1'b1;
            cntNext = 5'h00;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stReg <= ahi_pkg::SP_IDLE;
      cntReg <= 5'h00;
      inReg <= 32'h0000_0000;
      outReg <= 32'h0000_0000;
      sdoReg <= 1'b0;
      evtReg <= '0;
    end else if (clkEn) begin
      stReg <= stNext;
      cntReg <= cntNext;
      inReg <= inNext;
      outReg <= outNext;
      sdoReg <= sdoNext;
      evtReg <= evtNext;
    end
  end

  // Half-duplex: only the data phase of a read drives the pin
  assign sdoOe = (stReg == ahi_pkg::SP_READ) & enable & ~csS2;
  assign sdo = sdoReg;
  assign evt = evtReg;

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_sdo_float:
  assert property (stReg != ahi_pkg::SP_READ |-> !sdoOe)
    else $error("Serial output driven outside read data");
  a_cs_high_idle:
  assert property (clkEn && csS2 |=> stReg == ahi_pkg::SP_IDLE && !sdoOe)
    else $error("Port active while chip select high");
  a_reset_ignored:
  assert property (clkEn && !enable |=> stReg == ahi_pkg::SP_IDLE)
    else $error("Port active while held in reset");
  a_read_no_write:
  assert property (stReg == ahi_pkg::SP_READ |=> !evt.wrValid)
    else $error("Write word taken during a read");
  c_read_entry:
  cover property (stReg == ahi_pkg::SP_CMD ##1 stReg == ahi_pkg::SP_READ);

endmodule // ahi_spi_port
`default_nettype wire

// ==== hdl/ahi_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ahi_defs.svh"

module ahi_top #(
  parameter int FRAME_W = 24  // Two-wire frame length in bits
) (
  input  wire logic               core_clk,           // Master clock
  input  wire logic               sys_rst,            // Async reset
  input  wire logic               clkEn,              // Freeze when low
  input  wire logic               masterResetN,       // Master reset pin
  input  wire logic               watchdogRst,        // Watchdog reset
  input  wire logic               externalClockSel,   // 1: direct clock
  input  wire logic               xtalTick,           // Crystal edge
  input  wire logic               oscillatorIn,       // Osc in / strap
  input  wire logic               oscillatorOut,      // Mode select pin
  output logic                    oscillatorEnable,   // Crystal running
  input  wire logic [1:0]         prescaleSel,        // Prescale code
  input  wire logic [2:0]         ratioSel,           // Oversampling code
  input  wire logic               readyPinDriveSel,   // Idle drive high
  input  wire logic               bitstreamOutEnable, // Modulator out on
  input  wire logic               readyPinIn,         // Ready pin level
  output logic                    conversionReadyN,   // Ready pin out
  output logic                    conversionReadyOe,  // Ready pin drive
  input  wire logic               sck,                // Serial clock
  input  wire logic               csN,                // Chip select
  input  wire logic               sdi,                // Serial data in
  output logic                    sdo,                // Serial data out
  output logic                    sdoOe,              // Serial out drive
  input  wire logic [1:0]         wordLen,            // Word size code
  input  wire logic [31:0]        rdData,             // Read word
  input  wire logic [FRAME_W-1:0] frameData,          // Two-wire frame
  output ahi_pkg::ahi_spi_evt_s   spiEvt,             // Serial events
  output logic                    twoWireMode,        // Mode in force
  output ahi_pkg::ahi_strap_s     straps,             // Latched straps
  output logic                    analogClockTick,    // Analog clock
  output logic                    digitalSampleTick,  // Sample clock
  output logic                    outputRateTick      // Output rate
);

  localparam int CW = $clog2(FRAME_W + 1);

  // ---------------------------------------------
  // Divider arithmetic
  // ---------------------------------------------
  function automatic logic [2:0] preLast(input logic [1:0] pre);
    preLast = 3'((4'h1 << pre) - 4'h1);
  endfunction

  // Half a sample period is two analog periods
  function automatic logic [4:0] pulseWidth(input logic [1:0] pre);
    pulseWidth = 5'(6'h02 << pre);
  endfunction

  function automatic logic [11:0] ratioLast(input logic [2:0] sel);
    ratioLast = 12'((`AHI_RATIO_BASE << sel) - 13'h0001);
  endfunction

  // ---------------------------------------------
  // Declarations
  // ---------------------------------------------
  logic                oscS1, oscS2, oscS3, oscRise;
  logic [2:0]          preReg, preNext;
  logic [1:0]          digReg, digNext;
  logic [11:0]         rateReg, rateNext;
  logic [4:0]          pulseReg, pulseNext;
  logic                mclkTick, amTick, dmTick, rtTick;
  logic                pulseActive;
  logic                readyNReg, readyNNext, readyOeReg, readyOeNext;
  logic                capReg, capNext;
  ahi_pkg::ahi_if_e    modeReg, modeNext;
  ahi_pkg::ahi_strap_s strapReg, strapNext, strapPins;
  logic [FRAME_W-1:0]  twShiftReg, twShiftNext;
  logic [CW-1:0]       twCntReg, twCntNext;
  logic                twSdoReg, twSdoNext;
  logic                spiSdo, spiSdoOe, sckRise, sckFall;
  logic                twoWire, spiEnable;

  assign twoWire = (modeReg == ahi_pkg::IF_TWO_WIRE);
  assign spiEnable = ~twoWire & masterResetN;

  // ---------------------------------------------
  // Serial port
  // ---------------------------------------------
  ahi_spi_port u_spi (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clkEn    (clkEn),
    .enable   (spiEnable),
    .sck      (sck),
    .csN      (csN),
    .sdi      (sdi),
    .wordLen  (wordLen),
    .rdData   (rdData),
    .sdo      (spiSdo),
    .sdoOe    (spiSdoOe),
    .sckRise  (sckRise),
    .sckFall  (sckFall),
    .evt      (spiEvt)
  );

  // ---------------------------------------------
  // Master clock source
  // ---------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {oscS1, oscS2, oscS3} <= 3'h0;
    end else if (clkEn) begin
      {oscS1, oscS2, oscS3} <= {oscillatorIn, oscS1, oscS2};
    end
  end

  assign oscRise = oscS2 & ~oscS3;
  assign oscillatorEnable = ~externalClockSel;

  // Two-wire mode shares one clock for sampling and framing
  always_comb begin
    if (twoWire) begin
      mclkTick = sckRise;
    end else if (externalClockSel) begin
      mclkTick = clkEn & oscRise;
    end else begin
      mclkTick = clkEn & xtalTick;
    end
  end

  // ---------------------------------------------
  // Prescaler, sample and rate dividers
  // ---------------------------------------------
  always_comb begin
    preNext = preReg;
    digNext = digReg;
    rateNext = rateReg;
    pulseNext = pulseReg;
    amTick = 1'b0;
    dmTick = 1'b0;
    rtTick = 1'b0;
    if (!masterResetN) begin
      // No clock is distributed while held in master reset
      preNext = 3'h0;
      digNext = 2'h0;
      rateNext = 12'h000;
      pulseNext = 5'h00;
    end else if (mclkTick) begin
      if (pulseReg != 5'h00) begin
        pulseNext = pulseReg - 5'h01;
      end
      if (preReg >= preLast(prescaleSel)) begin
        preNext = 3'h0;
        amTick = 1'b1;
        if (digReg == `AHI_DIG_LAST) begin
          digNext = 2'h0;
          dmTick = 1'b1;
          if (rateReg >= ratioLast(ratioSel)) begin
            rateNext = 12'h000;
            rtTick = 1'b1;
            pulseNext = pulseWidth(prescaleSel);
          end else begin
            rateNext = rateReg + 12'h001;
          end
        end else begin
          digNext = digReg + 2'h1;
        end
      end else begin
        preNext = preReg + 3'h1;
      end
    end
  end

  assign pulseActive = (pulseReg != 5'h00);
  assign analogClockTick = amTick;
  assign digitalSampleTick = dmTick;
  assign outputRateTick = rtTick;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      preReg <= 3'h0;
      digReg <= 2'h0;
      rateReg <= 12'h000;
      pulseReg <= 5'h00;
    end else if (clkEn) begin
      preReg <= preNext;
      digReg <= digNext;
      rateReg <= rateNext;
      pulseReg <= pulseNext;
    end
  end

  // ---------------------------------------------
  // Ready pin
  // ---------------------------------------------
  // Pure timed pulse: nothing from the serial port feeds it, so a host
  // that misses a pulse gets no second chance.
  always_comb begin
    readyNNext = ~(pulseNext != 5'h00);
    readyOeNext = 1'b0;
    if (!twoWire && !bitstreamOutEnable) begin
      readyOeNext = (pulseNext != 5'h00) | readyPinDriveSel;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      readyNReg <= 1'b1;
      readyOeReg <= 1'b0;
    end else if (clkEn) begin
      readyNReg <= readyNNext;
      readyOeReg <= readyOeNext;
    end
  end

  assign conversionReadyN = readyNReg;
  assign conversionReadyOe = readyOeReg;

  // ---------------------------------------------
  // Interface mode and straps
  // ---------------------------------------------
  assign strapPins = '{gainStrapHi:  readyPinIn,
                       gainStrapLo:  oscillatorIn,
                       boostStrap:   csN,
                       ratioStrapHi: sdi,
                       ratioStrapLo: masterResetN};

  always_comb begin
    modeNext = modeReg;
    strapNext = strapReg;
    if (capReg && masterResetN) begin
      // Direct-clock select low means the pin carries a crystal
      modeNext = (externalClockSel && oscillatorOut) ?
                 ahi_pkg::IF_TWO_WIRE : ahi_pkg::IF_SPI;
      capNext = watchdogRst;
    end else begin
      capNext = capReg | watchdogRst | ~masterResetN;
    end
    if ((modeNext == ahi_pkg::IF_TWO_WIRE && !twoWire) ||
        (watchdogRst && twoWire)) begin
      strapNext = strapPins;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      capReg <= 1'b1;
      modeReg <= ahi_pkg::IF_SPI;
      strapReg <= '0;
    end else if (clkEn) begin
      capReg <= capNext;
      modeReg <= modeNext;
      strapReg <= strapNext;
    end
  end

  assign twoWireMode = twoWire;
  assign straps = strapReg;

  // ---------------------------------------------
  // Two-wire frame output
  // ---------------------------------------------
  // A new ready event restarts the frame; a host that clocks too slowly
  // loses the tail of the previous one.
  always_comb begin
    twShiftNext = twShiftReg;
    twCntNext = twCntReg;
    twSdoNext = twSdoReg;
    if (!twoWire) begin
      twCntNext = '0;
    end else if (rtTick) begin
      twShiftNext = frameData;
      twCntNext = CW'(FRAME_W);
    end else if (sckFall && twCntReg != '0) begin
      twSdoNext = twShiftReg[FRAME_W-1];
      twShiftNext = twShiftReg << 1;
      twCntNext = twCntReg - CW'(1);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      twShiftReg <= '0;
      twCntReg <= '0;
      twSdoReg <= 1'b0;
    end else if (clkEn) begin
      twShiftReg <= twShiftNext;
      twCntReg <= twCntNext;
      twSdoReg <= twSdoNext;
    end
  end

  assign sdo = twoWire ? twSdoReg : spiSdo;
  assign sdoOe = twoWire | spiSdoOe;

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  logic [4:0] widthCnt;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      widthCnt <= 5'h00;
    end else if (rtTick) begin
      widthCnt <= 5'h00;
    end else if (pulseActive && mclkTick) begin
      widthCnt <= widthCnt + 5'h01;
    end
  end

  a_ready_float:
  assert property (clkEn && !twoWire && !bitstreamOutEnable &&
                   !readyPinDriveSel && !(pulseNext != 5'h00)
                   |=> !conversionReadyOe)
    else $error("Ready pin driven while idle and float selected");
  a_ready_high:
  assert property (conversionReadyOe && !pulseActive |->
                   conversionReadyN &&
                   ($past(readyPinDriveSel) || !$past(clkEn)))
    else $error("Ready pin idle level wrong");
  a_pulse_start:
  assert property (clkEn && rtTick && !twoWire && !bitstreamOutEnable
                   |=> !conversionReadyN && conversionReadyOe)
    else $error("No ready pulse after conversion");
  a_pulse_width:
  assert property ($fell(pulseActive) && $past(masterResetN) &&
                   $stable(prescaleSel) |->
                   widthCnt == pulseWidth(prescaleSel))
    else $error("Ready pulse width not half a sample period");
  a_bitstream_off:
  assert property (clkEn && bitstreamOutEnable |=> !conversionReadyOe)
    else $error("Ready pin driven with bit-stream output on");
  a_ext_source:
  assert property (clkEn && !twoWire && externalClockSel && oscRise
                   |-> mclkTick)
    else $error("Direct clock edge not used as master clock");
  a_prescale:
  assert property (amTick |-> mclkTick && preReg >= preLast(prescaleSel))
    else $error("Analog clock tick off prescale");
  a_dig_div:
  assert property (dmTick |-> amTick && digReg == `AHI_DIG_LAST)
    else $error("Sample tick not every fourth analog tick");
  a_rate:
  assert property (rtTick |-> dmTick && rateReg >= ratioLast(ratioSel))
    else $error("Output rate tick off ratio");
  a_mode_hold:
  assert property (clkEn && !capReg && !watchdogRst && masterResetN
                   |=> $stable(modeReg))
    else $error("Mode changed without a reset");
  a_strap_entry:
  assert property ($rose(twoWire) |-> strapReg == $past(strapPins))
    else $error("Straps not sampled on two-wire entry");

  c_ready_pulse:
  cover property (!conversionReadyN ##1 conversionReadyN);
  c_two_wire:
  cover property ($rose(twoWire));
  c_frame_bit:
  cover property (twoWire && sckFall && twCntReg != '0);

endmodule // ahi_top
`default_nettype wire

// ==== tb/ahi_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ahi_host_model (
  input  wire logic clk,  // Bench clock
  input  wire logic sdo,  // Device data out
  output logic      sck,  // Serial clock
  output logic      csN,  // Chip select
  output logic      sdi   // Serial data in
);
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    sdi = 1'b1;
  end
  // Modes 0,0 and 1,1; sck stands at its idle level outside frames,
  // 12 cycle period
  task automatic xfer(input logic cpol, input logic [23:0] v,
                      output logic [23:0] got);
    sck = cpol;
    repeat (6) @(negedge clk);
    csN = 1'b0;
    repeat (6) @(negedge clk);
    for (int i = 23; i >= 0; i--) begin
      if (cpol) sck = 1'b0;
      sdi = v[i];
      repeat (6) @(negedge clk);
      sck = 1'b1;
      got[i] = sdo;
      repeat (6) @(negedge clk);
      if (!cpol) sck = 1'b0;
    end
    repeat (6) @(negedge clk);
    csN = 1'b1;
    sdi = ~sdi;
    repeat (8) @(negedge clk);
  endtask
endmodule  // ahi_host_model
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk, sys_rst, mRstN, extSel, drvSel, bsEn, clkEn, wdg, oscOut;
  logic [1:0] pre;
  logic [2:0] ratSel;
  logic [31:0] rdData;
  logic sck, csN, sdi, sdo, sdoOe, rdyN, rdyOe, oscEn, oeSeen, twMode;
  ahi_pkg::ahi_spi_evt_s evt;
  ahi_pkg::ahi_strap_s straps;
  logic [23:0] got;
  int num_errors, num_checks, nCmd, cyc, w, per;
  ahi_top u_ahi_top (.core_clk(core_clk), .sys_rst(sys_rst),
    .clkEn(clkEn), .masterResetN(mRstN), .watchdogRst(wdg),
    .externalClockSel(extSel), .xtalTick(1'b1), .oscillatorIn(1'b0),
    .oscillatorOut(oscOut), .oscillatorEnable(oscEn), .prescaleSel(pre),
    .ratioSel(ratSel), .readyPinDriveSel(drvSel),
    .bitstreamOutEnable(bsEn), .readyPinIn(1'b1),
    .conversionReadyN(rdyN), .conversionReadyOe(rdyOe), .sck(sck),
    .csN(csN), .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe), .wordLen(2'h0),
    .rdData(rdData), .frameData(24'h00_0000), .spiEvt(evt),
    .twoWireMode(twMode), .straps(straps), .analogClockTick(),
    .digitalSampleTick(), .outputRateTick());
  ahi_host_model u_ahi_host_model (.clk(core_clk), .sdo(sdo),
    .sck(sck), .csN(csN), .sdi(sdi));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(negedge core_clk) begin
    cyc++;
    if (evt.cmdValid === 1'b1) nCmd++;
    if (sdoOe !== 1'b0) oeSeen = 1'b1;
    if (cyc == 40000) begin
      num_errors++;
      report_and_stop;
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Waits up to 3000 cycles for a pulse, then measures width and period
  task automatic pulse;
    int n;
    n = 0; w = 0; per = 0;
    while (rdyN !== 1'b0 && n < 3000) begin @(negedge core_clk); n++; end
    while (rdyN === 1'b0 && w < 3000) begin @(negedge core_clk); w++; end
    per = w;
    while (rdyN !== 1'b0 && per < 3000) begin @(negedge core_clk); per++; end
  endtask
  task automatic t_spi;
    nCmd = 0; oeSeen = 1'b0;
    u_ahi_host_model.xfer(1'b0, {8'h02, 16'hA5C3}, got);
    chk(nCmd, 1);
    chk(evt.cmd, 8'h02);
    chk(evt.wrWord, 32'h0000_A5C3);
    chk(oeSeen, 0);
    u_ahi_host_model.xfer(1'b0, {8'h01, 16'hFFFF}, got);
    chk(got[15:0], 16'h5A3C);
    chk(evt.wrWord, 32'h0000_A5C3);
    chk(oeSeen, 1);
    chk(sdoOe, 0);
    u_ahi_host_model.xfer(1'b1, {8'h01, 16'h0000}, got);
    chk(got[15:0], 16'h5A3C);
    chk(nCmd, 3);
    mRstN = 1'b0; nCmd = 0; oeSeen = 1'b0;
    u_ahi_host_model.xfer(1'b0, {8'h01, 16'h0000}, got);
    chk(nCmd, 0);
    chk(oeSeen, 0);
    mRstN = 1'b1;
    $display("serial test done");
  endtask
  task automatic t_ready;
    for (int p = 0; p < 4; p++) begin
      pre = p[1:0];
      pulse;
      pulse;
      chk(w, 2 << p);
      chk(per, 128 << p);
      // Idle level is judged once the pulse is over
      while (rdyN === 1'b0) @(negedge core_clk);
      chk(rdyOe, drvSel);
      drvSel = ~drvSel;
    end
    pre = 2'h0;
    ratSel = 3'h1;
    pulse;
    pulse;
    chk(per, 256);
    bsEn = 1'b1;
    pulse;
    chk(rdyOe, 0);
    // Frozen clock must hold the pulse low well past its width
    bsEn = 1'b0;
    clkEn = 1'b0;
    repeat (20) @(negedge core_clk);
    chk(rdyN, 0);
    clkEn = 1'b1;
    $display("ready test done");
  endtask
  task automatic t_two_wire;
    extSel = 1'b1; oscOut = 1'b1; wdg = 1'b1;
    @(negedge core_clk);
    wdg = 1'b0;
    repeat (3) @(negedge core_clk);
    chk(oscEn, 0);
    chk(twMode, 1);
    chk(sdoOe, 1);
    chk(straps.gainStrapHi, 1);
    chk(straps.boostStrap, 1);
    oscOut = 1'b0;
    repeat (4) @(negedge core_clk);
    chk(twMode, 1);
    extSel = 1'b0; wdg = 1'b1;
    @(negedge core_clk);
    wdg = 1'b0;
    repeat (3) @(negedge core_clk);
    chk(twMode, 0);
    chk(sdoOe, 0);
    $display("two-wire test done");
  endtask
  initial begin
    sys_rst = 1'b1; mRstN = 1'b1; extSel = 1'b0; drvSel = 1'b1;
    bsEn = 1'b0; pre = 2'h0; rdData = 32'h5A3C_0000; oeSeen = 1'b0;
    clkEn = 1'b1; wdg = 1'b0; oscOut = 1'b0; ratSel = 3'h0;
    num_errors = 0; num_checks = 0; nCmd = 0; cyc = 0;
    repeat (5) @(negedge core_clk);
    chk(rdyN, 1);
    chk(sdoOe, 0);
    chk(oscEn, 1);
    sys_rst = 1'b0;
    repeat (3) @(negedge core_clk);
    t_spi;
    t_ready;
    t_two_wire;
    report_and_stop;
  end
endmodule  // tb_top
`default_nettype wire
